// *** dport_checker.sv ***
// Protocol checker on the thread to data port message link
`timescale 1ns/100ps
`default_nettype none
`include "dport_map.svh"
module dport_checker
    import dport_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         m_valid,
    input  wire logic         m_ready,
    input  wire logic         m_first,
    input  wire kind_e        m_kind,
    input  wire desc_t        m_desc,
    input  wire logic [15:0]  m_mask,
    input  wire logic         w_valid,
    input  wire logic [255:0] w_data,
    input  wire logic         done
);
    logic        take;
    logic [2:0]  cnt_r;
    logic [1:0]  wcnt_r;
    kind_e       kind_r;
    logic        bs16_r;
    logic        two_r;
    logic [15:0] mask_r;
    logic [2:0]  exp_m;
    logic [1:0]  exp_w;
    logic [7:0]  nz;
    assign take = m_valid && m_ready;
    // Shape of the message, caught at its first register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            kind_r <= KIND_READ;
            bs16_r <= 1'b0;
            two_r  <= 1'b0;
            mask_r <= 16'h0000;
        end
        else if (take && m_first)
        begin
            kind_r <= m_kind;
            bs16_r <= m_desc[9:8] == `BS_16DW;
            two_r  <= m_desc[`TWO_SRC_BIT];
            mask_r <= m_mask;
        end
    end
    // Registers taken and writeback beats seen, restarted by each first register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r  <= 3'h0;
            wcnt_r <= 2'h0;
        end
        else
        begin
            cnt_r  <= (take && m_first) ? 3'h1 : cnt_r + 3'(take);
            wcnt_r <= (take && m_first) ? 2'h0 : wcnt_r + 2'(w_valid);
        end
    end
    // Expected counts; a width slip here would hide a missing register
    assign exp_m = kind_r == KIND_READ ? (bs16_r ? 3'h2 : 3'h1) :
                   kind_r == KIND_WRITE ? (bs16_r ? 3'h4 : 3'h2) : (two_r ? 3'h3 : 3'h2);
    assign exp_w = kind_r == KIND_READ ? (bs16_r ? 2'h2 : 2'h1) :
                   kind_r == KIND_WRITE ? 2'h0 : 2'h1;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            nz[i] = |w_data[i*32 +: 32];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_bs_legal;
        m_valid && m_first && m_kind != KIND_ATOMIC |-> m_desc[9:8] inside {`BS_8DW, `BS_16DW};
    endproperty
    a_bs_legal: assert property (p_bs_legal)
        else $error("reserved block size sent");
    property p_two_src;
        m_valid && m_first && m_kind == KIND_ATOMIC |-> m_desc[12] == (m_desc[11:8] == `OP_CAS);
    endproperty
    a_two_src: assert property (p_two_src)
        else $error("two-source bit disagrees with opcode");
    property p_reg_count;
        done |-> cnt_r == exp_m;
    endproperty
    a_reg_count: assert property (p_reg_count)
        else $error("wrong number of message registers");
    property p_wb_count;
        done |-> (wcnt_r + {1'b0, w_valid}) == exp_w;
    endproperty
    a_wb_count: assert property (p_wb_count)
        else $error("wrong number of writeback registers");
    property p_latency;
        take && m_first |-> ##[9:40] done;
    endproperty
    a_latency: assert property (p_latency)
        else $error("message never finished");
    property p_done_pulse;
        done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    property p_wb_done;
        w_valid |-> ##[0:1] done;
    endproperty
    a_wb_done: assert property (p_wb_done)
        else $error("writeback beat not closed by done");
    property p_lane_mask;
        w_valid && kind_r != KIND_WRITE |->
            (nz & ~(wcnt_r == 2'h0 ? mask_r[7:0] : mask_r[15:8])) == 8'h00;
    endproperty
    a_lane_mask: assert property (p_lane_mask)
        else $error("masked lane returned data");
endmodule
`default_nettype wire

// *** dport_device.sv ***
// Data port end: scattered DWord read/write and 8-lane atomics on a buffer
`timescale 1ns/100ps
`default_nettype none
`include "dport_map.svh"

module dport_device
    import dport_pkg::*;
#(
    parameter int DEPTH = 1024
)(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [31:0] surf_elems,
    output logic             bad_msg,
    output logic             busy,
    dport_if.port            lnk
);
    localparam int AW = $clog2(DEPTH);

    // Refuse depths that the address slice below cannot cover exactly
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
        $error("DEPTH must be a power of two of at least 2");
    end

    typedef enum logic [1:0] {S_IDLE, S_COLLECT, S_EXEC, S_REPLY} state_e;

    state_e          state_r;
    kind_e           kind_r;
    desc_t           desc_r;
    logic [31:0]     gofs_r;
    logic [15:0]     mask_r;
    logic [255:0]    ph_r [0:`MAX_PHASES-1];
    logic [2:0]      ph_cnt_r;
    logic [3:0]      lane_r;
    logic [255:0]    res_r [0:1];
    logic            beat_r;
    logic [31:0]     mem [0:DEPTH-1];
    logic [255:0]    w_data_r;
    logic            w_valid_r;
    logic            done_r;
    logic            bad_r;

    // Lane n of a register sits in bits n*32 upward
    function automatic logic [31:0] lane_of(input logic [255:0] r, input logic [2:0] n);
        return r[n*`LANE_W +: `LANE_W];
    endfunction

    // Scattered messages carry one register per 8 lanes
    function automatic logic is16(input kind_e k, input desc_t d);
        return k != KIND_ATOMIC && d[`BS_LSB +: 2] == `BS_16DW;
    endfunction

    // Payload registers expected, header register included
    function automatic logic [2:0] phases(input kind_e k, input desc_t d);
        logic [2:0] n;
        n = is16(k, d) ? 3'h2 : 3'h1;
        if (k == KIND_WRITE)
            n = n + n;
        else if (k == KIND_ATOMIC)
            n = d[`TWO_SRC_BIT] ? 3'h3 : 3'h2;
        return n;
    endfunction

    // New memory value for one atomic lane
    function automatic logic [31:0] atomic_new(input atomic_op_t op, input logic [31:0] old,
                                               input logic [31:0] s0, input logic [31:0] s1);
        unique case (op)
            `OP_ADD:  return old + s0;
            `OP_SUB:  return old - s0;
            `OP_INC:  return old + 32'h00000001;
            `OP_DEC:  return old - 32'h00000001;
            `OP_UMIN: return (old < s0) ? old : s0;
            `OP_UMAX: return (old > s0) ? old : s0;
            `OP_SWAP: return s0;
            `OP_CAS:  return (old == s1) ? s0 : old;
            `OP_AND:  return old & s0;
            `OP_OR:   return old | s0;
            `OP_XOR:  return old ^ s0;
            `OP_SMIN: return ($signed(old) < $signed(s0)) ? old : s0;
            `OP_SMAX: return ($signed(old) > $signed(s0)) ? old : s0;
            default:  return old;
        endcase
    endfunction

    // Current lane decode, one lane per cycle so each access stands alone
    logic            cur16;
    logic [3:0]      nlanes_m1;
    logic [31:0]     ofs;
    logic [31:0]     dat;
    logic [31:0]     src1;
    logic [32:0]     eff;
    logic [33:0]     limit;
    logic            inb;
    logic            en;
    logic [31:0]     old;
    logic            do_wr;
    logic [31:0]     new_val;
    logic [2:0]      nofs;

    always_comb
    begin
        cur16     = is16(kind_r, desc_r);
        nofs      = cur16 ? 3'h2 : 3'h1;
        nlanes_m1 = cur16 ? 4'hF : 4'h7;
        ofs       = lane_of(ph_r[{2'h0, lane_r[3]}], lane_r[2:0]);
        if (kind_r == KIND_ATOMIC)
            dat = lane_of(ph_r[1], lane_r[2:0]);
        else
            dat = lane_of(ph_r[nofs + {2'h0, lane_r[3]}], lane_r[2:0]);
        src1  = lane_of(ph_r[2], lane_r[2:0]);
        eff   = {1'b0, gofs_r} + {1'b0, ofs};
        limit = {2'h0, surf_elems} << `ELEM_DW_SHIFT;
        inb   = ofs <= `OFS_MAX && {1'b0, eff} < limit && eff < 33'(DEPTH);
        en    = mask_r[lane_r] && !bad_r;
        old   = inb ? mem[eff[AW-1:0]] : 32'h00000000;
        new_val = (kind_r == KIND_ATOMIC) ? atomic_new(desc_r[`OP_LSB +: 4], old, dat, src1)
                                          : dat;
        do_wr = en && inb && kind_r != KIND_READ;
    end

    // Control sequencing: gather registers, walk lanes, send writeback
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r  <= S_IDLE;
            ph_cnt_r <= 3'h0;
            lane_r   <= 4'h0;
            beat_r   <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                S_IDLE:
                begin
                    if (lnk.m_valid && lnk.m_first)
                    begin
                        ph_cnt_r <= 3'h1;
                        lane_r   <= 4'h0;
                        state_r  <= (phases(lnk.m_kind, lnk.m_desc) == 3'h1) ? S_EXEC : S_COLLECT;
                    end
                end
                S_COLLECT:
                begin
                    if (lnk.m_valid)
                    begin
                        ph_cnt_r <= ph_cnt_r + 3'h1;
                        if (ph_cnt_r + 3'h1 == phases(kind_r, desc_r))
                            state_r <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    lane_r <= lane_r + 4'h1;
                    if (lane_r == nlanes_m1)
                    begin
                        beat_r  <= 1'b0;
                        state_r <= (kind_r == KIND_WRITE) ? S_IDLE : S_REPLY;
                    end
                end
                S_REPLY:
                begin
                    beat_r <= 1'b1;
                    if (beat_r || !cur16)
                        state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Message header and payload registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            kind_r <= KIND_READ;
            desc_r <= '0;
            gofs_r <= 32'h00000000;
            mask_r <= 16'h0000;
            bad_r  <= 1'b0;
            for (int i = 0; i < `MAX_PHASES; i++)
                ph_r[i] <= '0;
        end
        else if (lnk.m_valid && lnk.m_ready)
        begin
            // A stray non-first register in idle must not clobber the header
            if (state_r == S_IDLE && lnk.m_first)
            begin
                kind_r <= lnk.m_kind;
                desc_r <= lnk.m_desc;
                gofs_r <= lnk.m_gofs;
                // Atomics only ever use the low eight enables
                mask_r <= (lnk.m_kind == KIND_ATOMIC) ? {8'h00, lnk.m_mask[7:0]} : lnk.m_mask;
                // Reserved sizes or a stray two-source bit disable every lane
                bad_r  <= (lnk.m_kind != KIND_ATOMIC && !lnk.m_desc[`BS_LSB + 1])
                       || (lnk.m_kind == KIND_ATOMIC && lnk.m_desc[`TWO_SRC_BIT]
                           && lnk.m_desc[`OP_LSB +: 4] != `OP_CAS);
                ph_r[0] <= lnk.m_data;
            end
            else if (state_r == S_COLLECT)
                ph_r[ph_cnt_r] <= lnk.m_data;
        end
    end

    // Memory update, one lane per cycle
    always_ff @(posedge sys_clk)
    begin
        if (state_r == S_EXEC && do_wr)
            mem[eff[AW-1:0]] <= new_val;
    end

    // Result collection; disabled lanes read back as zero
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            res_r[0] <= '0;
            res_r[1] <= '0;
        end
        else if (state_r == S_IDLE)
        begin
            res_r[0] <= '0;
            res_r[1] <= '0;
        end
        else if (state_r == S_EXEC)
            res_r[lane_r[3]][lane_r[2:0]*`LANE_W +: `LANE_W] <= (en && inb) ? old : 32'h00000000;
    end

    // Writeback beats and completion pulse, all from flip-flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_valid_r <= 1'b0;
            w_data_r  <= '0;
            done_r    <= 1'b0;
        end
        else
        begin
            w_valid_r <= state_r == S_REPLY;
            w_data_r  <= (state_r == S_REPLY) ? res_r[beat_r] : '0;
            done_r    <= (state_r == S_REPLY && (beat_r || !cur16))
                      || (state_r == S_EXEC && lane_r == nlanes_m1 && kind_r == KIND_WRITE);
        end
    end

    assign lnk.m_ready = state_r == S_IDLE || state_r == S_COLLECT;
    assign lnk.w_valid = w_valid_r;
    assign lnk.w_data  = w_data_r;
    assign lnk.done    = done_r;
    assign bad_msg     = bad_r;
    assign busy        = state_r != S_IDLE;
endmodule
`default_nettype wire

// *** dport_if.sv ***
// Message link between a thread sender and the data port
`timescale 1ns/100ps
`default_nettype none
interface dport_if;
    import dport_pkg::*;
    logic           m_valid;
    logic           m_ready;
    logic           m_first;
    kind_e          m_kind;
    desc_t          m_desc;
    logic [31:0]    m_gofs;
    logic [15:0]    m_mask;
    logic [255:0]   m_data;
    logic           w_valid;
    logic [255:0]   w_data;
    logic           done;
    modport thread (output m_valid, m_first, m_kind, m_desc, m_gofs, m_mask, m_data,
                    input m_ready, w_valid, w_data, done);
    modport port   (input m_valid, m_first, m_kind, m_desc, m_gofs, m_mask, m_data,
                    output m_ready, w_valid, w_data, done);
endinterface
`default_nettype wire

// *** dport_map.svh ***
// Constants for the scattered DWord and atomic message port
`ifndef DPORT_MAP_SVH
`define DPORT_MAP_SVH
`define LANE_W        32
`define REG_W         256
`define LANES_PER_REG 8
`define MAX_PHASES    5
`define BS_LSB        8
`define BS_8DW        2'h2
`define BS_16DW       2'h3
`define OP_LSB        8
`define TWO_SRC_BIT   12
`define OFS_MAX       32'h03FFFFFF
`define ELEM_DW_SHIFT 2
`define OP_ADD        4'h0
`define OP_SUB        4'h1
`define OP_INC        4'h2
`define OP_DEC        4'h3
`define OP_UMIN       4'h4
`define OP_UMAX       4'h5
`define OP_SWAP       4'h6
`define OP_CAS        4'h7
`define OP_AND        4'h8
`define OP_OR         4'h9
`define OP_XOR        4'hA
`define OP_SMIN       4'hB
`define OP_SMAX       4'hC
`define A_STAGE_LAST  6'h27
`define A_CTRL        6'h28
`define A_GOFS        6'h29
`define A_MASK        6'h2A
`define A_GO          6'h2B
`define A_RES_FIRST   6'h30
`define CTRL_BS16     2
`define CTRL_OP_LSB   3
`endif

// *** dport_pkg.sv ***
// Types shared by both ends of the message port
package dport_pkg;
    typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_ATOMIC} kind_e;
    typedef logic [3:0]  atomic_op_t;
    typedef logic [13:0] desc_t;
endpackage

// *** dport_thread.sv ***
// Thread end: software-built messages sent to the data port
`timescale 1ns/100ps
`default_nettype none
`include "dport_map.svh"

module dport_thread
    import dport_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    dport_if.thread          lnk
);
    typedef enum logic [1:0] {T_IDLE, T_SEND, T_WAIT} tstate_e;

    tstate_e         state_r;
    logic [255:0]    stage_r [0:`MAX_PHASES-1];
    logic [31:0]     res_r [0:15];
    logic [7:0]      ctrl_r;
    logic [31:0]     gofs_r;
    logic [15:0]     mask_r;
    logic [2:0]      beat_r;
    logic            wbeat_r;
    logic            done_r;
    logic [31:0]     rdata_r;
    kind_e           kind;
    logic            bs16;
    atomic_op_t      op;
    logic [5:0]      widx;
    logic [2:0]      nph;

    assign widx = addr[7:2];
    assign kind = (ctrl_r[1:0] == 2'h2) ? KIND_ATOMIC : (ctrl_r[0] ? KIND_WRITE : KIND_READ);
    assign bs16 = ctrl_r[`CTRL_BS16] && kind != KIND_ATOMIC;
    assign op   = ctrl_r[`CTRL_OP_LSB +: 4];

    // Registers sent in the order staged: offsets, then data or sources
    always_comb
    begin
        nph = bs16 ? 3'h2 : 3'h1;
        if (kind == KIND_WRITE)
            nph = nph + nph;
        else if (kind == KIND_ATOMIC)
            nph = (op == `OP_CAS) ? 3'h3 : 3'h2;
    end

    // Software writes: staging registers and message fields; start is decoded by the sequencer
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r <= 8'h00;
            gofs_r <= 32'h00000000;
            mask_r <= 16'h0000;
            for (int i = 0; i < `MAX_PHASES; i++)
                stage_r[i] <= '0;
        end
        else if (wr)
        begin
            if (widx <= `A_STAGE_LAST)
                stage_r[widx[5:3]][widx[2:0]*`LANE_W +: `LANE_W] <= wdata;
            else if (widx == `A_CTRL)
                ctrl_r <= wdata[7:0];
            else if (widx == `A_GOFS)
                gofs_r <= wdata;
            else if (widx == `A_MASK)
                mask_r <= wdata[15:0];
        end
    end

    // Message sequencing; a new start is ignored while busy
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= T_IDLE;
            beat_r  <= 3'h0;
        end
        else
        begin
            unique case (state_r)
                T_IDLE:
                begin
                    beat_r <= 3'h0;
                    if (wr && widx == `A_GO && wdata[0])
                        state_r <= T_SEND;
                end
                T_SEND:
                begin
                    if (lnk.m_ready)
                    begin
                        beat_r <= beat_r + 3'h1;
                        if (beat_r + 3'h1 == nph)
                            state_r <= T_WAIT;
                    end
                end
                T_WAIT:
                begin
                    if (lnk.done)
                        state_r <= T_IDLE;
                end
            endcase
        end
    end

    // Writeback capture; done is sticky and its set beats a clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wbeat_r <= 1'b0;
            done_r  <= 1'b0;
            for (int i = 0; i < 16; i++)
                res_r[i] <= 32'h00000000;
        end
        else
        begin
            if (lnk.w_valid)
            begin
                for (int i = 0; i < `LANES_PER_REG; i++)
                    res_r[{wbeat_r, 3'(i)}] <= lnk.w_data[i*`LANE_W +: `LANE_W];
                wbeat_r <= 1'b1;
            end
            if (state_r == T_IDLE)
                wbeat_r <= 1'b0;
            if (lnk.done && state_r == T_WAIT)
                done_r <= 1'b1;
            else if (wr && widx == `A_GO && wdata[1])
                done_r <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped words read zero
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= 32'h00000000;
        else if (rd)
        begin
            if (widx <= `A_STAGE_LAST)
                rdata_r <= stage_r[widx[5:3]][widx[2:0]*`LANE_W +: `LANE_W];
            else if (widx == `A_CTRL)
                rdata_r <= {24'h000000, ctrl_r};
            else if (widx == `A_GOFS)
                rdata_r <= gofs_r;
            else if (widx == `A_MASK)
                rdata_r <= {16'h0000, mask_r};
            else if (widx == `A_GO)
                rdata_r <= {30'h00000000, done_r, state_r != T_IDLE};
            else if (widx >= `A_RES_FIRST)
                rdata_r <= res_r[widx[3:0]];
            else
                rdata_r <= 32'h00000000;
        end
        else
            rdata_r <= 32'h00000000;
    end

    assign rdata       = rdata_r;
    assign lnk.m_valid = state_r == T_SEND;
    assign lnk.m_first = state_r == T_SEND && beat_r == 3'h0;
    assign lnk.m_kind  = kind;
    // Block size is always a legal code; two-source only for compare-and-swap
    assign lnk.m_desc  = (kind == KIND_ATOMIC)
                       ? {1'b0, op == `OP_CAS, op, 8'h00}
                       : {4'h0, bs16 ? `BS_16DW : `BS_8DW, 8'h00};
    assign lnk.m_gofs  = gofs_r;
    assign lnk.m_mask  = mask_r;
    assign lnk.m_data  = stage_r[beat_r];
endmodule
`default_nettype wire

// *** scattered_dword_atomic_port_tb_top.sv ***
// Self-checking bench: thread end and data port joined over the message link
`timescale 1ns/100ps
`default_nettype none
`include "dport_map.svh"
module scattered_dword_atomic_port_tb_top;
    import dport_pkg::*;
    localparam int DEPTH = 64;
    // Untiled linear buffer at DWord 0 with a limit of 32 DWords, below DEPTH
    localparam int SURF = 8;
    logic        sys_clk;
    logic        arst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] surf_elems;
    logic        dev_busy;
    logic        dev_bad;
    int          n_errors;
    int          checks_done;
    int          seed;
    int          cycles;
    logic [31:0] mem [DEPTH];
    logic [31:0] stg [40];
    dport_if lnk ();
    dport_thread dport_thread_inst (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk));
    dport_device #(.DEPTH(DEPTH)) dport_device_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .surf_elems(surf_elems), .bad_msg(dev_bad), .busy(dev_busy), .lnk(lnk));
    dport_checker dport_checker_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .m_valid(lnk.m_valid), .m_ready(lnk.m_ready), .m_first(lnk.m_first),
        .m_kind(lnk.m_kind), .m_desc(lnk.m_desc), .m_mask(lnk.m_mask),
        .w_valid(lnk.w_valid), .w_data(lnk.w_data), .done(lnk.done));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Hang guard; the full run needs a few thousand cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input int idx, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= 8'(idx * 4);
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input int idx, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= 8'(idx * 4);
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [31:0] alu(input logic [3:0] op, input logic [31:0] a, s0, s1);
        case (op)
            4'h0: return a + s0;
            4'h1: return a - s0;
            4'h2: return a + 32'h1;
            4'h3: return a - 32'h1;
            4'h4: return a < s0 ? a : s0;
            4'h5: return a > s0 ? a : s0;
            4'h6: return s0;
            4'h7: return a == s1 ? s0 : a;
            4'h8: return a & s0;
            4'h9: return a | s0;
            4'hA: return a ^ s0;
            4'hB: return $signed(a) < $signed(s0) ? a : s0;
            4'hC: return $signed(a) > $signed(s0) ? a : s0;
            default: return a;
        endcase
    endfunction
    // Stage registers, run one message, update the model lane by lane, compare
    task automatic msg(input int kind, input bit b16, input logic [3:0] op, input int g,
                       input logic [15:0] m, input int nreg);
        logic [31:0] v;
        logic [31:0] ea;
        logic [31:0] old;
        logic        ok;
        int          n;
        logic [31:0] res [16];
        for (int i = 0; i < nreg * 8; i++)
            wreg(i, stg[i]);
        wreg(`A_CTRL, 32'(kind) | (32'(b16) << 2) | (32'(op) << 3));
        wreg(`A_GOFS, 32'(g));
        wreg(`A_MASK, {16'h0000, m});
        rreg(`A_MASK, v);
        check(v, {16'h0000, m});
        wreg(`A_GO, 32'h1);
        v = 32'h0;
        for (int i = 0; i < 60 && v[1] !== 1'b1; i++)
            rreg(`A_GO, v);
        // Done with the thread idle again; the device idle with a legal header
        check(v, 32'h2);
        check({30'h0, dev_bad, dev_busy}, 32'h0);
        wreg(`A_GO, 32'h2);
        rreg(`A_GO, v);
        check(v, 32'h0);
        n = (kind == 2 || !b16) ? 8 : 16;
        // Lanes in order, so a repeated atomic offset sees the earlier lane's result
        for (int i = 0; i < n; i++)
        begin
            ea = 32'(g) + stg[i];
            ok = m[i] && stg[i] <= `OFS_MAX && ea < DEPTH && ea < 4 * surf_elems;
            old = ok ? mem[ea] : 32'h0;
            res[i] = old;
            if (ok && kind == 1)
                mem[ea] = stg[(b16 ? 16 : 8) + i];
            if (ok && kind == 2)
                mem[ea] = alu(op, old, stg[8 + i], stg[16 + i]);
        end
        for (int i = 0; i < n && kind != 1; i++)
        begin
            rreg(`A_RES_FIRST + i, v);
            check(v, res[i]);
        end
    endtask
    initial
    begin
        seed = 42766;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        surf_elems = 32'(SURF);
        arst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        // Known contents for words 0..31 before anything reads them
        for (int h = 0; h < 2; h++)
        begin
            for (int i = 0; i < 16; i++)
            begin
                stg[i] = 32'(i);
                stg[16 + i] = $random(seed);
            end
            msg(1, 1'b1, 4'h0, h * 16, 16'hFFFF, 4);
        end
        // Reads and writes of both sizes; distinct offsets, some past the limit
        for (int r = 0; r < 8; r++)
        begin
            for (int i = 0; i < 40; i++)
                stg[i] = $random(seed);
            for (int i = 0; i < 16; i++)
                stg[i] = 32'((i * 3 + r * 5) % 40);
            stg[15] = 32'h0400_0000;
            // Offsets step by 3 modulo 40, so no two write lanes overlap
            msg(r % 2, r[1], 4'h0, {$random(seed)} % 4, 16'($random(seed)),
                (r % 2 + 1) * (r[1] + 1));
        end
        // Every atomic opcode, a repeated offset, half the compares made to match
        for (int op = 0; op < 16; op++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                stg[i] = {$random(seed)} % 40;
                stg[8 + i] = $random(seed);
            end
            stg[1] = stg[0];
            // Shrink the surface on some opcodes so the bound moves under the atomics
            @(posedge sys_clk);
            surf_elems <= 32'(SURF - op % 3);
            for (int i = 0; i < 8; i++)
                stg[16 + i] = (stg[i] < 32 && i % 2 == 0) ? mem[stg[i]] : $random(seed);
            msg(2, 1'b0, 4'(op), 0, 16'($random(seed)) | 16'h0005, op == 7 ? 3 : 2);
        end
        // Read every word back over the full surface
        @(posedge sys_clk);
        surf_elems <= 32'(SURF);
        for (int h = 0; h < 2; h++)
        begin
            for (int i = 0; i < 16; i++)
                stg[i] = 32'(i);
            msg(0, 1'b1, 4'h0, h * 16, 16'hFFFF, 2);
        end
        test_done();
    end
endmodule
`default_nettype wire
